// ---- rtl/pec_pkg.sv ----
// Constants shared by the performance event counter block.
// Assumes a single core clock; the core gates it during sleep.
package pec_pkg;
    // Register selects
    localparam logic [2:0]  SEL_CTL0 = 3'h0;
    localparam logic [2:0]  SEL_CNT0 = 3'h1;
    localparam logic [2:0]  SEL_CTL1 = 3'h2;
    localparam logic [2:0]  SEL_CNT1 = 3'h3;
    localparam logic [2:0]  SEL_TRC  = 3'h4;
    // Widths
    localparam int          CNT_W    = 32;
    localparam int          EV_W     = 7;
    localparam int          NUM_EV   = 128;
    localparam int          TC_W     = 8;
    localparam int          VPE_W    = 4;
    // Control register fields
    localparam int          C_MORE   = 31;
    localparam int          C_TC_LO  = 22;
    localparam int          C_TC_HI  = 29;
    localparam int          C_SC_LO  = 20;
    localparam int          C_SC_HI  = 21;
    localparam int          C_VP_LO  = 16;
    localparam int          C_VP_HI  = 19;
    localparam int          C_BLOCK  = 15;
    localparam int          C_EV_LO  = 5;
    localparam int          C_EV_HI  = 11;
    localparam int          C_IE     = 4;
    localparam int          C_USER   = 3;
    localparam int          C_SUPER  = 2;
    localparam int          C_KERN   = 1;
    localparam int          C_EXL    = 0;
    localparam logic [31:0] CTL_WMASK = 32'h3FFF_8FFF;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic        MORE0    = 1'b1;
    localparam logic        MORE1    = 1'b0;
    // Trace extra control fields
    localparam int          T_OVF    = 13;
    localparam int          T_CALL   = 12;
    localparam int          T_BP     = 11;
    localparam int          T_SYNC   = 10;
    localparam int          T_MEN    = 9;
    localparam int          T_PRES   = 8;
    localparam logic [31:0] TRC_WMASK = 32'h0000_3C00;
    localparam logic [31:0] TRC_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;
    // Scope encodings
    localparam logic [1:0]  SCOPE_ALL = 2'h0;
    localparam logic [1:0]  SCOPE_VPE = 2'h1;
    localparam logic [1:0]  SCOPE_TC  = 2'h2;
    // Current privilege level encodings
    localparam logic [1:0]  MODE_KERN  = 2'h0;
    localparam logic [1:0]  MODE_SUPER = 2'h1;
    localparam logic [1:0]  MODE_USER  = 2'h2;
    // Events that ignore the mode bits, one table per counter
    localparam logic [127:0] NOMODE0 = 128'h0000_0000_0000_000F_0FFC_1090_0264_0001;
    localparam logic [127:0] NOMODE1 = 128'h0000_0000_0000_000F_1FFD_4090_0260_0001;
endpackage

// ---- rtl/pec_counter.sv ----
// One 32-bit event counter with software load.
// Assumes clk is the core's gated clock, stopped in sleep.
`timescale 1ns/100ps
module pec_counter (
    input  wire logic        clk,     // Gated core clock
    input  wire logic        reset,   // Async reset, active high
    input  wire logic        load,    // Software write this cycle
    input  wire logic [31:0] wr_data, // Value to load
    input  wire logic        inc,     // Qualified event this cycle
    output logic      [31:0] count_r  // Current count
);
    logic [31:0] count_nxt; // Next count

    // Software load beats a same-cycle event; the event is dropped
    assign count_nxt = load ? wr_data : (inc ? count_r + 32'h0000_0001 : count_r);

    // Count register; it only moves on edges of the gated clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= pec_pkg::CNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule

// ---- rtl/pec_event_sel.sv ----
// Event picker and qualifier for one counter.
// Assumes event pulses arrive from same-clock pipeline logic.
`timescale 1ns/100ps
module pec_event_sel #(
    parameter logic [127:0] NOMODE = 128'h0 // Mode-insensitive events
) (
    input  wire logic [127:0] ev_hit,   // One pulse per event number
    input  wire logic [6:0]   ev_sel,   // Selected event number
    input  wire logic [3:0]   mode_en,  // User, super, kernel, exl enables
    input  wire logic [1:0]   cur_mode, // Privilege of the event's context
    input  wire logic         cur_exl,  // Exception level
    input  wire logic         cur_erl,  // Error level
    input  wire logic [1:0]   scope,    // Counting scope
    input  wire logic [7:0]   tc_sel,   // Chosen thread context
    input  wire logic [3:0]   vpe_sel,  // Chosen virtual cpu
    input  wire logic [7:0]   ev_tc,    // Context that raised the event
    input  wire logic [3:0]   ev_vpe,   // Virtual cpu that raised the event
    output logic              inc       // Qualified count pulse
);
    logic hit;      // Selected event fired
    logic no_mode;  // Event ignores the mode bits
    logic mode_ok;  // Current mode is enabled
    logic scope_ok; // Event's origin is in scope
    logic lvl_clr;  // Neither exception nor error level

    // Each counter has its own table, so one number means two events
    assign hit     = ev_hit[ev_sel];
    assign no_mode = NOMODE[ev_sel];
    assign lvl_clr = !cur_exl && !cur_erl;

    // Mode qualification
    assign mode_ok = (mode_en[pec_pkg::C_USER]  && lvl_clr && cur_mode == pec_pkg::MODE_USER)
                  || (mode_en[pec_pkg::C_SUPER] && lvl_clr && cur_mode == pec_pkg::MODE_SUPER)
                  || (mode_en[pec_pkg::C_KERN]  && lvl_clr && cur_mode == pec_pkg::MODE_KERN)
                  || (mode_en[pec_pkg::C_EXL]   && cur_exl && !cur_erl);

    // Scope filter; any context may be counted, not only the owner
    assign scope_ok = (scope == pec_pkg::SCOPE_ALL)
                   || (scope == pec_pkg::SCOPE_VPE && ev_vpe == vpe_sel)
                   || (scope == pec_pkg::SCOPE_TC  && ev_tc == tc_sel);

    // Reserved scope and reserved events simply never count
    assign inc = hit && (no_mode || mode_ok) && scope_ok;
endmodule

// ---- rtl/pec_perf_counters.sv ----
// Performance event counter block for one core, shared by its contexts.
// Assumes move_to/move_from strobes from the pipeline on clk,
// which is the core's gated clock.
`timescale 1ns/100ps
module pec_perf_counters #(
    parameter bit HAS_COUNTERS  = 1'b1, // Counter logic built in
    parameter bit TRACE_PRESENT = 1'b1  // Counter tracing built in
) (
    input  wire logic         clk,              // Gated core clock
    input  wire logic         reset,            // Async reset, active high
    input  wire logic [2:0]   sel,              // Register select
    input  wire logic         move_to_sysctl,   // Register write strobe
    input  wire logic         wr_vpe,           // Virtual cpu doing the write
    input  wire logic [31:0]  wr_data,          // Write data
    input  wire logic         move_from_sysctl, // Register read strobe
    input  wire logic [127:0] ev0_hit,          // Counter 0 event pulses
    input  wire logic [127:0] ev1_hit,          // Counter 1 event pulses
    input  wire logic [1:0]   cur_mode,         // Privilege of event context
    input  wire logic         cur_exl,          // Exception level
    input  wire logic         cur_erl,          // Error level
    input  wire logic [7:0]   ev_tc,            // Event's thread context
    input  wire logic [3:0]   ev_vpe,           // Event's virtual cpu
    input  wire logic         trig_call_return, // Call, return or exception
    input  wire logic         trig_breakpoint,  // Breakpoint match
    input  wire logic         trig_sync_expiry, // Sync counter expired
    output logic [31:0]       rd_data_r,        // Read data
    output logic              rd_valid_r,       // Read data valid pulse
    output logic              irq_vpe0_r,       // Interrupt to virtual cpu 0
    output logic              irq_vpe1_r,       // Interrupt to virtual cpu 1
    output logic [1:0]        trace_emit_r,     // Counter value emitted
    output logic [31:0]       trace_val0_r,     // Emitted counter 0 value
    output logic [31:0]       trace_val1_r      // Emitted counter 1 value
);
    logic [31:0] ctl0_r;      // Counter 0 control, writable bits only
    logic [31:0] ctl1_r;      // Counter 1 control, writable bits only
    logic        owner0_r;    // Last writer of control 0
    logic        owner1_r;    // Last writer of control 1
    logic [31:0] trc_r;       // Trace extra control, writable bits
    logic [1:0]  top_d_r;     // Count bit 31 one cycle ago
    logic [31:0] cnt0;        // Counter 0 value
    logic [31:0] cnt1;        // Counter 1 value
    logic        inc0;        // Counter 0 qualified event
    logic        inc1;        // Counter 1 qualified event
    logic        wr_ctl0;     // Write decode
    logic        wr_cnt0;
    logic        wr_ctl1;
    logic        wr_cnt1;
    logic        wr_trc;
    logic [31:0] ctl0_view;   // Control 0 as software reads it
    logic [31:0] ctl1_view;   // Control 1 as software reads it
    logic [31:0] trc_view;    // Trace control as software reads it
    logic [31:0] trc_wmask;   // Writable trace bits for this build
    logic [31:0] rd_nxt;      // Read mux result
    logic        req0;        // Counter 0 interrupt condition
    logic        req1;        // Counter 1 interrupt condition
    logic        irq0_nxt;
    logic        irq1_nxt;
    logic        ovf_any;     // Some counter crossed into bit 31
    logic        trig_any;    // Enabled trace trigger fired
    logic [1:0]  emit_nxt;

    // Write decode; with no counters the four registers ignore writes
    assign wr_ctl0 = move_to_sysctl && sel == pec_pkg::SEL_CTL0 && HAS_COUNTERS;
    assign wr_cnt0 = move_to_sysctl && sel == pec_pkg::SEL_CNT0 && HAS_COUNTERS;
    assign wr_ctl1 = move_to_sysctl && sel == pec_pkg::SEL_CTL1 && HAS_COUNTERS;
    assign wr_cnt1 = move_to_sysctl && sel == pec_pkg::SEL_CNT1 && HAS_COUNTERS;
    assign wr_trc  = move_to_sysctl && sel == pec_pkg::SEL_TRC;

    // Master enable is only writable when counters exist
    assign trc_wmask = pec_pkg::TRC_WMASK
                     | (HAS_COUNTERS ? (32'h0000_0001 << pec_pkg::T_MEN) : 32'h0);

    // Read views: preset flags merged in, reserved bits stay zero
    assign ctl0_view = ctl0_r | ({31'h0, pec_pkg::MORE0} << pec_pkg::C_MORE);
    assign ctl1_view = ctl1_r | ({31'h0, pec_pkg::MORE1} << pec_pkg::C_MORE);
    assign trc_view  = trc_r  | ({31'h0, TRACE_PRESENT} << pec_pkg::T_PRES);

    // Read mux; counter registers read all ones when absent
    assign rd_nxt = (sel == pec_pkg::SEL_TRC) ? trc_view
                  : (sel > pec_pkg::SEL_CNT1) ? 32'h0000_0000
                  : !HAS_COUNTERS             ? pec_pkg::ALL_ONES
                  : (sel == pec_pkg::SEL_CTL0) ? ctl0_view
                  : (sel == pec_pkg::SEL_CNT0) ? cnt0
                  : (sel == pec_pkg::SEL_CTL1) ? ctl1_view
                  : cnt1;

    // Event pickers, one per counter with its own decode table
    pec_event_sel #(
        .NOMODE (pec_pkg::NOMODE0)
    ) u_sel0 (
        .ev_hit   (ev0_hit),
        .ev_sel   (ctl0_r[pec_pkg::C_EV_HI:pec_pkg::C_EV_LO]),
        .mode_en  (ctl0_r[pec_pkg::C_USER:pec_pkg::C_EXL]),
        .cur_mode (cur_mode),
        .cur_exl  (cur_exl),
        .cur_erl  (cur_erl),
        .scope    (ctl0_r[pec_pkg::C_SC_HI:pec_pkg::C_SC_LO]),
        .tc_sel   (ctl0_r[pec_pkg::C_TC_HI:pec_pkg::C_TC_LO]),
        .vpe_sel  (ctl0_r[pec_pkg::C_VP_HI:pec_pkg::C_VP_LO]),
        .ev_tc    (ev_tc),
        .ev_vpe   (ev_vpe),
        .inc      (inc0)
    );
    pec_event_sel #(
        .NOMODE (pec_pkg::NOMODE1)
    ) u_sel1 (
        .ev_hit   (ev1_hit),
        .ev_sel   (ctl1_r[pec_pkg::C_EV_HI:pec_pkg::C_EV_LO]),
        .mode_en  (ctl1_r[pec_pkg::C_USER:pec_pkg::C_EXL]),
        .cur_mode (cur_mode),
        .cur_exl  (cur_exl),
        .cur_erl  (cur_erl),
        .scope    (ctl1_r[pec_pkg::C_SC_HI:pec_pkg::C_SC_LO]),
        .tc_sel   (ctl1_r[pec_pkg::C_TC_HI:pec_pkg::C_TC_LO]),
        .vpe_sel  (ctl1_r[pec_pkg::C_VP_HI:pec_pkg::C_VP_LO]),
        .ev_tc    (ev_tc),
        .ev_vpe   (ev_vpe),
        .inc      (inc1)
    );

    // Counters; the interrupt never holds or reloads them
    pec_counter u_cnt0 (
        .clk     (clk),
        .reset   (reset),
        .load    (wr_cnt0),
        .wr_data (wr_data),
        .inc     (inc0 && HAS_COUNTERS),
        .count_r (cnt0)
    );
    pec_counter u_cnt1 (
        .clk     (clk),
        .reset   (reset),
        .load    (wr_cnt1),
        .wr_data (wr_data),
        .inc     (inc1 && HAS_COUNTERS),
        .count_r (cnt1)
    );

    // Interrupt condition per counter, steered to its owner
    assign req0     = cnt0[31] && ctl0_r[pec_pkg::C_IE];
    assign req1     = cnt1[31] && ctl1_r[pec_pkg::C_IE];
    assign irq0_nxt = (req0 && !owner0_r) || (req1 && !owner1_r);
    assign irq1_nxt = (req0 && owner0_r) || (req1 && owner1_r);

    // Trace triggers; overflow means bit 31 just became set
    assign ovf_any  = (cnt0[31] && !top_d_r[0]) || (cnt1[31] && !top_d_r[1]);
    assign trig_any = trc_r[pec_pkg::T_MEN] && TRACE_PRESENT
                   && ((trc_r[pec_pkg::T_OVF]  && ovf_any)
                    || (trc_r[pec_pkg::T_CALL] && trig_call_return)
                    || (trc_r[pec_pkg::T_BP]   && trig_breakpoint)
                    || (trc_r[pec_pkg::T_SYNC] && trig_sync_expiry));
    assign emit_nxt = {trig_any && !ctl1_r[pec_pkg::C_BLOCK],
                       trig_any && !ctl0_r[pec_pkg::C_BLOCK]};

    // Control registers and their last writer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl0_r   <= pec_pkg::CTL_RESET; // Enable and trace block clear
            ctl1_r   <= pec_pkg::CTL_RESET;
            owner0_r <= 1'b0;
            owner1_r <= 1'b0;
        end else begin
            if (wr_ctl0) begin
                ctl0_r   <= wr_data & pec_pkg::CTL_WMASK;
                owner0_r <= wr_vpe;
            end
            if (wr_ctl1) begin
                ctl1_r   <= wr_data & pec_pkg::CTL_WMASK;
                owner1_r <= wr_vpe;
            end
        end
    end

    // Trace extra control; reset leaves tracing disabled
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trc_r <= pec_pkg::TRC_RESET;
        end else if (wr_trc) begin
            trc_r <= wr_data & trc_wmask;
        end
    end

    // Read port, one cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_r  <= 32'h0000_0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= move_from_sysctl;
            if (move_from_sysctl) begin
                rd_data_r <= rd_nxt;
            end
        end
    end

    // Registered interrupt outputs, one per virtual cpu
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_vpe0_r <= 1'b0;
            irq_vpe1_r <= 1'b0;
        end else begin
            irq_vpe0_r <= irq0_nxt;
            irq_vpe1_r <= irq1_nxt;
        end
    end

    // Trace emission; values are captured with the pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            top_d_r      <= 2'h0;
            trace_emit_r <= 2'h0;
            trace_val0_r <= 32'h0000_0000;
            trace_val1_r <= 32'h0000_0000;
        end else begin
            top_d_r      <= {cnt1[31], cnt0[31]};
            trace_emit_r <= emit_nxt;
            trace_val0_r <= cnt0;
            trace_val1_r <= cnt1;
        end
    end

    // Checks
    a_absent_reads: assert property (@(posedge clk) disable iff (reset)
        (move_from_sysctl && sel <= pec_pkg::SEL_CNT1 && !HAS_COUNTERS)
        |=> rd_data_r == pec_pkg::ALL_ONES)
        else $error("absent counters did not read all ones");
    a_irq_formed: assert property (@(posedge clk) disable iff (reset)
        (cnt0[31] && ctl0_r[pec_pkg::C_IE]) |=> (irq_vpe0_r || irq_vpe1_r))
        else $error("counter 0 interrupt not raised");
    a_irq_owner: assert property (@(posedge clk) disable iff (reset)
        wr_ctl0 |=> owner0_r == $past(wr_vpe))
        else $error("control 0 owner not taken from writer");
    a_count_runs: assert property (@(posedge clk) disable iff (reset)
        ((irq_vpe0_r || irq_vpe1_r) && inc0 && HAS_COUNTERS && !wr_cnt0)
        |=> cnt0 == $past(cnt0) + 32'h0000_0001)
        else $error("counter 0 stalled while interrupt raised");
    a_irq_drop: assert property (@(posedge clk) disable iff (reset)
        (!req0 && !req1) |=> (!irq_vpe0_r && !irq_vpe1_r))
        else $error("interrupt held without a cause");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
        (move_from_sysctl && sel == pec_pkg::SEL_CTL1 && HAS_COUNTERS)
        |=> (rd_data_r[30] == 1'b0 && rd_data_r[14:12] == 3'h0))
        else $error("reserved control bits read nonzero");
    a_trace_block: assert property (@(posedge clk) disable iff (reset)
        trace_emit_r[0] |-> !$past(ctl0_r[pec_pkg::C_BLOCK]))
        else $error("blocked counter 0 was traced");
    a_master_gate: assert property (@(posedge clk) disable iff (reset)
        (trace_emit_r != 2'h0) |-> $past(trc_r[pec_pkg::T_MEN]))
        else $error("trace emitted with master enable off");

    // A qualified event moves the count by exactly one
    // Catches a stuck or double-stepping counter even with interrupts off
    a_count_step: assert property (@(posedge clk) disable iff (reset)
        (inc1 && HAS_COUNTERS && !wr_cnt1) |=> cnt1 == $past(cnt1) + 32'h0000_0001)
        else $error("counter 1 did not step by one");

    // A software write loads the count whole, a same-cycle event is lost
    // The load must win so software sees exactly what it wrote
    a_count_load: assert property (@(posedge clk) disable iff (reset)
        wr_cnt0 |=> cnt0 == $past(wr_data))
        else $error("counter 0 load lost");

    // Control 1 interrupt follows its own last writer
    // Both controls keep separate owners; one must not steer the other
    a_irq_owner1: assert property (@(posedge clk) disable iff (reset)
        wr_ctl1 |=> owner1_r == $past(wr_vpe))
        else $error("control 1 owner not taken from writer");

    // Counter 1 request reaches one of the two interrupt outputs
    // The output is registered, hence the one-cycle lag
    a_irq_formed1: assert property (@(posedge clk) disable iff (reset)
        req1 |=> (irq_vpe0_r || irq_vpe1_r))
        else $error("counter 1 interrupt not raised");

    // Every read strobe is answered with a valid pulse
    // Software relies on the fixed one-cycle answer
    a_rd_valid: assert property (@(posedge clk) disable iff (reset)
        move_from_sysctl |=> rd_valid_r)
        else $error("read strobe not answered");

    // Control 0 reports that a second pair follows it
    // The flag is a constant, never taken from written data
    a_more_flag: assert property (@(posedge clk) disable iff (reset)
        (move_from_sysctl && sel == pec_pkg::SEL_CTL0 && HAS_COUNTERS)
        |=> rd_data_r[31] == pec_pkg::MORE0)
        else $error("control 0 preset flag wrong");

    // Trace control reports whether counter tracing is built in
    a_pres_flag: assert property (@(posedge clk) disable iff (reset)
        (move_from_sysctl && sel == pec_pkg::SEL_TRC)
        |=> rd_data_r[pec_pkg::T_PRES] == TRACE_PRESENT)
        else $error("trace present flag wrong");

    // Emitted value is the count at the trigger cycle
    // A stale value here would skew every traced measurement
    a_trace_val: assert property (@(posedge clk) disable iff (reset)
        trace_emit_r[1] |-> trace_val1_r == $past(cnt1))
        else $error("traced counter 1 value wrong");

    // Reserved control 0 bits stay zero on every read when counters are built in
    a_rsvd_zero0: assert property (@(posedge clk) disable iff (reset)
        (move_from_sysctl && sel == pec_pkg::SEL_CTL0 && HAS_COUNTERS)
        |=> (rd_data_r[30] == 1'b0 && rd_data_r[14:12] == 3'h0))
        else $error("reserved control 0 bits read nonzero");
endmodule

// ---- testbench/pec_event_src.sv ----
// Stand-in for the pipeline event sources feeding both counters.
// Assumes the bench changes ev_num and active just after a clock edge.
`timescale 1ns/100ps
module pec_event_src (
    input  wire logic [6:0]   ev_num, // Event number raised
    input  wire logic         active, // Event fires this cycle
    output logic      [127:0] ev_hit  // One-hot pulses, low when idle
);
    // Only one event at a time, so a miscount points at the qualifier
    always_comb begin
        ev_hit = 128'h0;
        if (active) begin
            ev_hit[ev_num] = 1'b1;
        end
    end
endmodule

// ---- testbench/pec_perf_counters_test.sv ----
// Self-checking bench for the performance event counter block.
// Assumes the rtl package and modules are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module pec_perf_counters_test;
    logic clk, reset, mt, mf, wr_vpe, act, tcr, tbp, tsy, error_level, exception_level_count;
    logic [2:0]   sel;       // Register select
    logic [31:0]  wr_data;   // Write data
    logic [6:0]   ev_num;    // Event raised by the source model
    logic [127:0] ev_hit;    // Event pulses
    logic [1:0]   cur_mode;  // Privilege of the event
    logic [7:0]   ev_tc;     // Event context
    logic [31:0]  rd_data_r, rd2, d;
    logic         rd_valid_r, irq0, irq1;
    logic [1:0]   emit;      // Trace emit pulse
    logic [31:0]  tv1;       // Traced counter 1 value
    int           bad_count, tests_run;
    pec_event_src src (.ev_num(ev_num), .active(act), .ev_hit(ev_hit));
    pec_perf_counters uut (.clk(clk), .reset(reset), .sel(sel), .move_to_sysctl(mt),
        .wr_vpe(wr_vpe), .wr_data(wr_data), .move_from_sysctl(mf), .ev0_hit(ev_hit),
        .ev1_hit(ev_hit), .cur_mode(cur_mode), .cur_exl(exception_level_count), .cur_erl(error_level),
        .ev_tc(ev_tc), .ev_vpe(4'h0), .trig_call_return(tcr), .trig_breakpoint(tbp),
        .trig_sync_expiry(tsy), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .irq_vpe0_r(irq0), .irq_vpe1_r(irq1), .trace_emit_r(emit),
        .trace_val0_r(), .trace_val1_r(tv1));
    // Build without counter logic, sharing the same register traffic
    pec_perf_counters #(.HAS_COUNTERS(1'b0)) uut2 (.clk(clk), .reset(reset), .sel(sel),
        .move_to_sysctl(mt), .wr_vpe(wr_vpe), .wr_data(wr_data), .move_from_sysctl(mf),
        .ev0_hit(ev_hit), .ev1_hit(ev_hit), .cur_mode(cur_mode), .cur_exl(exception_level_count),
        .cur_erl(error_level), .ev_tc(ev_tc), .ev_vpe(4'h0), .trig_call_return(tcr),
        .trig_breakpoint(tbp), .trig_sync_expiry(tsy), .rd_data_r(rd2), .rd_valid_r(),
        .irq_vpe0_r(), .irq_vpe1_r(), .trace_emit_r(), .trace_val0_r(), .trace_val1_r());
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Every task starts and ends 1 ns after a rising edge
    task automatic wr(input logic [2:0] s, input logic [31:0] v);
        sel = s; wr_data = v; mt = 1'b1;
        @(posedge clk); #1 mt = 1'b0;
    endtask
    task automatic rd(input logic [2:0] s, input logic [31:0] exp);
        sel = s; mf = 1'b1;
        @(posedge clk); #1 mf = 1'b0;
        `CHK(rd_valid_r, 1'b1)
        `CHK(rd_data_r, exp)
    endtask
    task automatic run(input int n);
        act = 1'b1;
        repeat (n) @(posedge clk);
        #1 act = 1'b0;
    endtask
    task automatic reset_values();
        rd(3'h0, 32'h8000_0000);
        `CHK(rd2, 32'hFFFF_FFFF)
        rd(3'h2, 32'h0000_0000);
        rd(3'h4, 32'h0000_0100);
        rd(3'h5, 32'h0000_0000);
    endtask
    task automatic reg_access();
        wr(3'h2, 32'hFFFF_FFFF);
        rd(3'h2, 32'h3FFF_8FFF);
        wr(3'h3, 32'hA5A5_5A5A);
        rd(3'h3, 32'hA5A5_5A5A);
        `CHK(rd2, 32'hFFFF_FFFF)
        wr(3'h2, 32'h0000_0000);
        wr(3'h3, 32'h0000_0000);
    endtask
    task automatic counting();
        // Cycles need no mode bit; event 1 is user-mode only here (no reserved events)
        ev_num = 7'h00; wr(3'h1, 32'h0); run(5);
        rd(3'h1, 32'h0000_0005);
        ev_num = 7'h01; wr(3'h0, 32'h0000_0028); wr(3'h1, 32'h0);
        cur_mode = pec_pkg::MODE_KERN; run(4);
        rd(3'h1, 32'h0);
        cur_mode = pec_pkg::MODE_USER; run(3);
        rd(3'h1, 32'h0000_0003);
        // Context scope, context 5 chosen
        ev_num = 7'h00; wr(3'h0, 32'h0160_0000); wr(3'h1, 32'h0);
        ev_tc = 8'h03; run(4);
        rd(3'h1, 32'h0);
        ev_tc = 8'h05; run(2);
        rd(3'h1, 32'h0000_0002);
    endtask
    task automatic interrupt();
        ev_num = 7'h00; wr_vpe = 1'b1; ev_tc = 8'h00;
        wr(3'h0, 32'h0000_0010); wr(3'h1, 32'h7FFF_FFFF); run(1);
        for (int i = 0; i < 4 && irq1 !== 1'b1; i++) @(posedge clk) #1;
        `CHK(irq1, 1'b1)
        `CHK(irq0, 1'b0)
        run(3);
        rd(3'h1, 32'h8000_0003);
        wr(3'h1, 32'h0); @(posedge clk) #1;
        `CHK(irq1, 1'b0)
        wr_vpe = 1'b0;
    endtask
    task automatic trace_on(input logic [31:0] ctl, input logic [1:0] exp);
        logic [1:0] got;
        got = 2'b00; wr(3'h4, ctl); tbp = 1'b1;
        @(posedge clk); #1 tbp = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (emit !== 2'b00 && got === 2'b00) got = emit;
            @(posedge clk) #1;
        end
        `CHK(got, exp)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        reset = 1'b1; mt = 1'b0; mf = 1'b0; wr_vpe = 1'b0; act = 1'b0; sel = 3'h0;
        wr_data = 32'h0; ev_num = 7'h0; cur_mode = pec_pkg::MODE_KERN; exception_level_count = 1'b0;
        error_level = 1'b0; ev_tc = 8'h0; tcr = 1'b0; tbp = 1'b0; tsy = 1'b0;
        bad_count = 0; tests_run = 0;
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        reset_values();
        reg_access();
        counting();
        interrupt();
        trace_on(32'h0000_0800, 2'b00);
        trace_on(32'h0000_0A00, 2'b11);
        `CHK(tv1, 32'h0000_000F)
        wr(3'h2, 32'h0000_8000);
        trace_on(32'h0000_0A00, 2'b01);
        rd(3'h4, 32'h0000_0B00);
        summarize();
    end
endmodule
